// [verilog/rsm_top.sv]
/*
 * Reset and sleep manager: gathers reset sources, drives the cold,
 * global, port-configuration and sleep reset lines, runs the active,
 * standby and sleep modes, records the reset cause and holds the
 * keyed watchdog, with its registers on APB.
 * Assumes all inputs synchronous to mclk and a CPU that restarts at
 * address zero while its reset is low.
 */
// How it works
// - Power-on or pin reset clears all bits, forces RC on, crystal off.
// - Leaving sleep by pin combination keeps every cold-reset bit.
// - Non-cold reset clears global bits, port bits if enabled, resets CPU.
// - HALT enters standby; CPU stops, clocks keep running.
// - Standby ends on any reset or an enabled interrupt or event.
// - Sleep stops clocks and peripherals and holds sleep reset low.
// - Sleep entered only when sleep bit written while unlock is one.
// - Sleep left only by power-on, pin reset or pin combination.
// - Slept flag reads one if slept since last cleared.
// - Control bit 7 is sleep unlock, written by software, cleared by cold reset.
// - Control bit 6 enables port-configuration reset with global reset.
// - Control bit 5 enables illegal-access reset; bits 3..0 read zero.
// - Control bit 4 enables watchdog reset; software cannot clear it.
// - Cause bit 7 is sleep command, reads zero, global-reset cleared.
// - Cause bit 6 is slept flag, cleared by read and cold reset.
// - Cause bits 5..3 record reset causes, cleared on read.
// - Watchdog writes give key byte; reads give counter, upper zero.
// - Counter cleared by 0x0A then 0x03 written back to back, or by global reset.
// - Counter runs 0 to 8 and holds at 8; reaching 8 resets when enabled.
// - Global reset on cold or enabled source; cold only power-on/pin.
// - Enabled unused-address access resets and sets its cause flag.
`include "rsm_consts.svh"
module rsm_top
	import rsm_pkg::*;
#(
	parameter int unsigned WDOG_TICK_CYCLES =
		`RSM_WDOG_TICK_MS * `RSM_CLK_KHZ
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ext_reset_n,
	input wire logic pin_combo_reset,
	input wire logic bad_access,
	input wire logic halt_req,
	input wire logic wake_req,
	input wire rsm_pkg::rsm_apb_req_type apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cold_reset_n,
	output logic global_reset_n,
	output logic pconf_reset_n,
	output logic sleep_reset_n,
	output logic cpu_reset_n,
	output logic cpu_div_reset,
	output logic rc_osc_force,
	output logic xtal_osc_off,
	output logic clk_run,
	output logic standby,
	output logic port_cfg_reset_en
);
	import rsm_pkg::*;

	localparam int TICK_W = $clog2(WDOG_TICK_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST =
		TICK_W'(WDOG_TICK_CYCLES - 1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	rsm_mode_type mode_q, mode_d;
	logic sleep_unlock_q, pcfg_en_q, bad_en_q, wdog_en_q;
	logic slept_q, cause_bad_q, cause_wdog_q, cause_combo_q;
	logic [3:0] wdog_cnt_q;
	logic wdog_armed_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [2:0] rst_cnt_q;
	logic [7:0] rd_byte_q;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire setup = apb_req.psel & ~apb_req.penable;
	wire access = apb_req.psel & apb_req.penable & pready;
	wire wr = access & apb_req.pwrite;
	wire rd = access & ~apb_req.pwrite;
	wire sel_ctrl = apb_req.paddr == `RSM_OFS_CTRL;
	wire sel_cause = apb_req.paddr == `RSM_OFS_CAUSE;
	wire sel_wdog = apb_req.paddr == `RSM_OFS_WDOG;
	wire mapped = sel_ctrl | sel_cause | sel_wdog;
	wire [7:0] wbyte = apb_req.pwdata[7:0];
	wire wr_ctrl = wr & sel_ctrl;
	wire wr_wdog = wr & sel_wdog;
	wire rd_cause = rd & sel_cause;

	// ------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------
	wire cold_in = ~ext_reset_n;
	wire in_sleep = mode_q == RSM_SLEEP;
	wire wdog_hit = wdog_cnt_q == `RSM_WDOG_LIMIT;
	wire wdog_fire = wdog_en_q & wdog_hit & ~in_sleep;
	wire bad_fire = bad_en_q & bad_access & ~in_sleep;
	wire combo_fire = pin_combo_reset & ~cold_in;
	wire event_any = (wdog_fire | bad_fire | combo_fire) & ~cold_in;
	wire glob_hold = cold_in | (rst_cnt_q != `RSM_RST_IDLE);
	wire glob_any = glob_hold | event_any;
	wire sleep_cmd = wr & sel_cause & wbyte[`RSM_BIT_SLEEP_CMD]
		& sleep_unlock_q & mode_q == RSM_ACTIVE & ~glob_any;
	wire tick = tick_cnt_q == TICK_LAST;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	wire [7:0] ctrl_rd = {sleep_unlock_q, pcfg_en_q, bad_en_q, wdog_en_q,
		4'h0};
	wire [7:0] cause_rd = {1'b0, slept_q, cause_bad_q, cause_wdog_q,
		cause_combo_q, 3'h0};
	wire [7:0] wdog_rd = {4'h0, wdog_cnt_q};
	wire [7:0] rd_sel = sel_ctrl ? ctrl_rd :
		sel_cause ? cause_rd :
		sel_wdog ? wdog_rd : `RSM_BYTE_ZERO;

	// ------------------------------------------------------------
	// APB slave, zero wait states
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			rd_byte_q <= `RSM_BYTE_ZERO;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= setup ? {24'h00_0000, rd_sel} : 32'h0000_0000;
			rd_byte_q <= setup ? rd_sel : `RSM_BYTE_ZERO;
		end
	end

	// ------------------------------------------------------------
	// Control register, cold-reset bits
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sleep_unlock_q <= 1'b0;
			pcfg_en_q <= 1'b0;
			bad_en_q <= 1'b0;
			wdog_en_q <= 1'b0;
		end else if (cold_in) begin
			sleep_unlock_q <= 1'b0;
			pcfg_en_q <= 1'b0;
			bad_en_q <= 1'b0;
			wdog_en_q <= 1'b0;
		end else if (wr_ctrl) begin
			sleep_unlock_q <= wbyte[`RSM_BIT_SLEEP_UNLOCK];
			pcfg_en_q <= wbyte[`RSM_BIT_PCFG_EN];
			bad_en_q <= wbyte[`RSM_BIT_BAD_EN];
			wdog_en_q <= wdog_en_q | wbyte[`RSM_BIT_WDOG_EN];
		end
	end

	// ------------------------------------------------------------
	// Cause register, set wins over clear-on-read
	// ------------------------------------------------------------
	wire rc_slept = rd_cause & rd_byte_q[`RSM_BIT_SLEPT];
	wire rc_bad = rd_cause & rd_byte_q[`RSM_BIT_CAUSE_BAD];
	wire rc_wdog = rd_cause & rd_byte_q[`RSM_BIT_CAUSE_WDOG];
	wire rc_combo = rd_cause & rd_byte_q[`RSM_BIT_CAUSE_COMBO];

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			slept_q <= 1'b0;
			cause_bad_q <= 1'b0;
			cause_wdog_q <= 1'b0;
			cause_combo_q <= 1'b0;
		end else if (cold_in) begin
			slept_q <= 1'b0;
			cause_bad_q <= 1'b0;
			cause_wdog_q <= 1'b0;
			cause_combo_q <= 1'b0;
		end else begin
			slept_q <= sleep_cmd | (slept_q & ~rc_slept);
			cause_bad_q <= bad_fire | (cause_bad_q & ~rc_bad);
			cause_wdog_q <= wdog_fire | (cause_wdog_q & ~rc_wdog);
			cause_combo_q <= combo_fire | (cause_combo_q & ~rc_combo);
		end
	end

	// ------------------------------------------------------------
	// Global reset stretch
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_cnt_q <= `RSM_RST_IDLE;
		end else if (cold_in) begin
			rst_cnt_q <= `RSM_RST_IDLE;
		end else if (event_any) begin
			rst_cnt_q <= `RSM_RST_PULSE;
		end else if (rst_cnt_q != `RSM_RST_IDLE) begin
			rst_cnt_q <= rst_cnt_q - `RSM_RST_STEP;
		end
	end

	// ------------------------------------------------------------
	// Watchdog tick, counter and key
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt_q <= '0;
		end else if (glob_any || in_sleep || tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
		end
	end

	wire key_clear = wr_wdog & wdog_armed_q
		& wbyte == `RSM_WDOG_KEY_CLEAR;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wdog_cnt_q <= `RSM_WDOG_ZERO;
			wdog_armed_q <= 1'b0;
		end else if (glob_any) begin
			wdog_cnt_q <= `RSM_WDOG_ZERO;
			wdog_armed_q <= 1'b0;
		end else begin
			if (wr_wdog) begin
				wdog_armed_q <= wbyte == `RSM_WDOG_KEY_ARM;
			end
			if (key_clear) begin
				wdog_cnt_q <= `RSM_WDOG_ZERO;
			end else if (tick && !wdog_hit) begin
				wdog_cnt_q <= wdog_cnt_q + `RSM_WDOG_STEP;
			end
		end
	end

	// ------------------------------------------------------------
	// Operating mode
	// ------------------------------------------------------------
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			RSM_ACTIVE: begin
				if (sleep_cmd) begin
					mode_d = RSM_SLEEP;
				end else if (halt_req && !glob_any) begin
					mode_d = RSM_STANDBY;
				end
			end
			RSM_STANDBY: begin
				if (glob_any || wake_req) begin
					mode_d = RSM_ACTIVE;
				end
			end
			RSM_SLEEP: begin
				if (combo_fire) begin
					mode_d = RSM_ACTIVE;
				end
			end
			default: mode_d = RSM_ACTIVE;
		endcase
		if (cold_in) begin
			mode_d = RSM_ACTIVE;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			mode_q <= RSM_ACTIVE;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ------------------------------------------------------------
	// Reset and clock outputs
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cold_reset_n <= 1'b0;
			global_reset_n <= 1'b0;
			pconf_reset_n <= 1'b0;
			sleep_reset_n <= 1'b0;
			cpu_reset_n <= 1'b0;
			cpu_div_reset <= 1'b1;
			rc_osc_force <= 1'b1;
			xtal_osc_off <= 1'b1;
			clk_run <= 1'b1;
			standby <= 1'b0;
			port_cfg_reset_en <= 1'b0;
		end else begin
			cold_reset_n <= ~cold_in;
			global_reset_n <= ~glob_any;
			pconf_reset_n <= ~(cold_in | (glob_any & pcfg_en_q));
			sleep_reset_n <= ~(cold_in | mode_d == RSM_SLEEP);
			cpu_reset_n <= ~glob_any;
			cpu_div_reset <= glob_any;
			rc_osc_force <= cold_in;
			xtal_osc_off <= cold_in;
			clk_run <= mode_d != RSM_SLEEP;
			standby <= mode_d == RSM_STANDBY;
			port_cfg_reset_en <= pcfg_en_q;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_sleep_gate;
		wr & sel_cause & wbyte[`RSM_BIT_SLEEP_CMD] & ~sleep_unlock_q
			|=> mode_q != RSM_SLEEP || $past(mode_q) == RSM_SLEEP;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate)
		else $error("sleep entered while locked");

	property p_sleep_wake;
		in_sleep & ~cold_in & ~pin_combo_reset |=> in_sleep;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake)
		else $error("sleep left without a wake source");

	property p_sleep_line;
		in_sleep & ~combo_fire & ~cold_in |=> ~sleep_reset_n & ~clk_run;
	endproperty
	a_sleep_line: assert property (p_sleep_line)
		else $error("sleep reset or clock stop missing");

	property p_wdog_lock;
		wdog_en_q & ~cold_in |=> wdog_en_q;
	endproperty
	a_wdog_lock: assert property (p_wdog_lock)
		else $error("watchdog enable cleared by software");

	property p_wdog_fire;
		wdog_en_q & wdog_hit & ~in_sleep & ~cold_in
			|=> ~global_reset_n & cause_wdog_q ##1 wdog_cnt_q == 4'h0;
	endproperty
	a_wdog_fire: assert property (p_wdog_fire)
		else $error("watchdog overflow gave no reset");

	property p_key_pair;
		wr_wdog & wbyte == 8'h0A & ~glob_any ##[2:3]
			wr_wdog & wbyte == 8'h03 & ~glob_any |=> wdog_cnt_q == 4'h0;
	endproperty
	a_key_pair: assert property (p_key_pair)
		else $error("key pair did not clear the counter");

	property p_key_only;
		$changed(wdog_cnt_q) & ~$past(glob_any) |->
			wdog_cnt_q == $past(wdog_cnt_q) + 4'h1 || $past(key_clear);
	endproperty
	a_key_only: assert property (p_key_only)
		else $error("counter changed without a cause");

	property p_bad_reset;
		bad_fire & ~cold_in |=> ~global_reset_n & ~cpu_reset_n
			& cause_bad_q;
	endproperty
	a_bad_reset: assert property (p_bad_reset)
		else $error("illegal access gave no reset");

	property p_combo_keep;
		in_sleep & combo_fire & sleep_unlock_q |=> sleep_unlock_q
			& slept_q & cause_combo_q;
	endproperty
	a_combo_keep: assert property (p_combo_keep)
		else $error("pin combination wake lost cold bits");

	property p_standby;
		mode_q == RSM_STANDBY & (wake_req | glob_any) |=>
			mode_q == RSM_ACTIVE & ~standby;
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby not left on wake");

	property p_cold_clear;
		cold_in |=> ~sleep_unlock_q & ~pcfg_en_q & ~slept_q
			& ~cold_reset_n & rc_osc_force & xtal_osc_off;
	endproperty
	a_cold_clear: assert property (p_cold_clear)
		else $error("cold reset left bits set");

	property p_pconf;
		~cold_in & event_any |=> pconf_reset_n == ~$past(pcfg_en_q);
	endproperty
	a_pconf: assert property (p_pconf)
		else $error("port reset not per its enable");

endmodule // rsm_top

// [inc/rsm_consts.svh]
/*
 * Constants of the reset and sleep manager: register offsets, field
 * positions, reset values, key codes and timing figures.
 * Assumes inclusion by the package and the design file only.
 */
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RSM_ADDR_W 4
`define RSM_OFS_CTRL 4'h0
`define RSM_OFS_CAUSE 4'h4
`define RSM_OFS_WDOG 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSM_BIT_SLEEP_UNLOCK 7
`define RSM_BIT_PCFG_EN 6
`define RSM_BIT_BAD_EN 5
`define RSM_BIT_WDOG_EN 4
`define RSM_BIT_SLEEP_CMD 7
`define RSM_BIT_SLEPT 6
`define RSM_BIT_CAUSE_BAD 5
`define RSM_BIT_CAUSE_WDOG 4
`define RSM_BIT_CAUSE_COMBO 3

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define RSM_BYTE_ZERO 8'h00
`define RSM_WDOG_KEY_ARM 8'h0A
`define RSM_WDOG_KEY_CLEAR 8'h03
`define RSM_WDOG_ZERO 4'h0
`define RSM_WDOG_LIMIT 4'h8
`define RSM_WDOG_STEP 4'h1
`define RSM_RST_PULSE 3'h4
`define RSM_RST_STEP 3'h1
`define RSM_RST_IDLE 3'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSM_CLK_KHZ 50000
`define RSM_WDOG_TICK_MS 250

`endif

// [inc/rsm_pkg.sv]
/*
 * Types of the reset and sleep manager: operating modes and the
 * APB request carrier.
 * Assumes the constants header is on the include path.
 */
`include "rsm_consts.svh"

package rsm_pkg;

	// ------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RSM_ACTIVE = 3'b001,
		RSM_STANDBY = 3'b010,
		RSM_SLEEP = 3'b100
	} rsm_mode_type;

	// ------------------------------------------------------------
	// APB request
	// ------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [`RSM_ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} rsm_apb_req_type;

endpackage

// [dv/rsm_cpu_model.sv]
/*
 * Model of the CPU core and peripherals fed by the reset lines.
 * Assumes the manager's reset outputs and clk_run on mclk.
 */
module rsm_cpu_model (
	input wire logic mclk,
	input wire logic cpu_reset_n,
	input wire logic pconf_reset_n,
	input wire logic clk_run,
	output logic [15:0] pc,
	output int restarts,
	output int pconf_hits
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------
	// Program counter and reset tallies
	// ----------------------------------------------------------
	initial begin
		restarts = 0;
		pconf_hits = 0;
	end
	always @(posedge mclk) begin
		if (cpu_reset_n !== 1'b1)
			pc <= 16'h0000;
		else if (clk_run === 1'b1)
			pc <= pc + 16'h0001;
	end
	always @(negedge cpu_reset_n)
		restarts++;
	always @(negedge pconf_reset_n)
		pconf_hits++;
endmodule // rsm_cpu_model

// [dv/reset_sleep_manager_tb.sv]
/*
 * Self-checking bench of the reset and sleep manager over APB.
 * Assumes rsm_pkg compiled first and the tick shortened to 4 cycles.
 */
module reset_sleep_manager_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rsm_pkg::*;
	logic mclk, nrst, ext_reset_n, pin_combo_reset, bad_access;
	logic halt_req, wake_req, pready, pslverr, cold_reset_n;
	logic global_reset_n, pconf_reset_n, sleep_reset_n, cpu_reset_n;
	logic cpu_div_reset, rc_osc_force, xtal_osc_off, clk_run, standby;
	logic port_cfg_reset_en, err;
	logic [31:0] prdata, rd;
	logic [15:0] pc;
	rsm_apb_req_type apb_req;
	int restarts, pconf_hits, mismatches, check_count, cyc, n0, r0;
	bit seen, seen_cold, seen_div;

	rsm_top #(.WDOG_TICK_CYCLES(4)) uut (
		.mclk(mclk), .nrst(nrst), .ext_reset_n(ext_reset_n),
		.pin_combo_reset(pin_combo_reset), .bad_access(bad_access),
		.halt_req(halt_req), .wake_req(wake_req), .apb_req(apb_req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cold_reset_n(cold_reset_n), .global_reset_n(global_reset_n),
		.pconf_reset_n(pconf_reset_n), .sleep_reset_n(sleep_reset_n),
		.cpu_reset_n(cpu_reset_n), .cpu_div_reset(cpu_div_reset),
		.rc_osc_force(rc_osc_force), .xtal_osc_off(xtal_osc_off),
		.clk_run(clk_run), .standby(standby),
		.port_cfg_reset_en(port_cfg_reset_en)
	);
	rsm_cpu_model partner (
		.mclk(mclk), .cpu_reset_n(cpu_reset_n),
		.pconf_reset_n(pconf_reset_n), .clk_run(clk_run), .pc(pc),
		.restarts(restarts), .pconf_hits(pconf_hits)
	);
	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] sv,
		input logic [31:0] ev);
		check_count++;
		if (sv !== ev) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ev, sv);
		end
	endtask
	task automatic apb(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge mclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb_req <= '0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [3:0] a,
		input logic [31:0] ev);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, ev);
	endtask
	task automatic watch(input int n);
		seen = 0;
		seen_cold = 0;
		seen_div = 0;
		repeat (n) begin
			@(posedge mclk);
			if (global_reset_n === 1'b0)
				seen = 1;
			if (cpu_div_reset === 1'b1)
				seen_div = 1;
			if (cold_reset_n !== 1'b1)
				seen_cold = 1;
		end
	endtask
	task automatic settle();
		while (global_reset_n !== 1'b1) begin
			@(posedge mclk);
		end
	endtask
	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_regs();
		rdc("ctrl rst", 4'h0, 32'h0);
		rdc("cause rst", 4'h4, 32'h0);
		chk("xtal off", xtal_osc_off, 1'b0);
		wr(4'h0, 32'hEF);
		rdc("ctrl rw", 4'h0, 32'hE0);
		chk("pcfg en", port_cfg_reset_en, 1'b1);
		wr(4'h0, 32'h0);
		rdc("ctrl clr", 4'h0, 32'h0);
		apb(1'b0, 4'hC, 32'h0);
		chk("unmapped err", err, 1'b1);
		chk("unmapped data", rd, 32'h0);
	endtask
	task automatic t_wdog();
		repeat (40) @(posedge mclk);
		rdc("wd sat", 4'h8, 32'h8);
		wr(4'h8, 32'h0A);
		wr(4'h8, 32'h03);
		apb(1'b0, 4'h8, 32'h0);
		chk("wd cleared", rd < 2, 1'b1);
		repeat (40) @(posedge mclk);
		wr(4'h8, 32'h0A);
		wr(4'h8, 32'h05);
		wr(4'h8, 32'h03);
		rdc("wd kept", 4'h8, 32'h8);
	endtask
	task automatic t_bad();
		wr(4'h0, 32'h40);
		@(posedge mclk) bad_access <= 1'b1;
		@(posedge mclk) bad_access <= 1'b0;
		watch(10);
		chk("bad off", seen, 1'b0);
		wr(4'h0, 32'h60);
		n0 = pconf_hits;
		r0 = restarts;
		@(posedge mclk) bad_access <= 1'b1;
		@(posedge mclk) bad_access <= 1'b0;
		watch(10);
		chk("bad on", seen, 1'b1);
		chk("no cold", seen_cold, 1'b0);
		chk("div rst", seen_div, 1'b1);
		settle();
		apb(1'b0, 4'h8, 32'h0);
		chk("wd glob", rd < 4, 1'b1);
		chk("pconf", 32'(pconf_hits - n0), 32'h1);
		chk("cpu rst", 32'(restarts - r0), 32'h1);
		rdc("cause bad", 4'h4, 32'h20);
		rdc("cause rc", 4'h4, 32'h0);
		rdc("ctrl kept", 4'h0, 32'h60);
	endtask
	task automatic t_standby();
		@(posedge mclk) halt_req <= 1'b1;
		@(posedge mclk) halt_req <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("stby", standby, 1'b1);
		chk("stby clk", clk_run, 1'b1);
		@(posedge mclk) wake_req <= 1'b1;
		@(posedge mclk) wake_req <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("stby wake", standby, 1'b0);
		@(posedge mclk) halt_req <= 1'b1;
		@(posedge mclk) halt_req <= 1'b0;
		@(posedge mclk) pin_combo_reset <= 1'b1;
		@(posedge mclk) pin_combo_reset <= 1'b0;
		watch(8);
		settle();
		chk("stby rst", standby, 1'b0);
		rdc("cause combo", 4'h4, 32'h08);
	endtask
	task automatic t_sleep();
		wr(4'h4, 32'h80);
		repeat (2) @(posedge mclk);
		chk("locked", sleep_reset_n, 1'b1);
		rdc("cmd reads 0", 4'h4, 32'h0);
		wr(4'h0, 32'hA0);
		// Bus left idle after the command
		wr(4'h4, 32'h80);
		repeat (2) @(posedge mclk);
		chk("sleep rst", sleep_reset_n, 1'b0);
		chk("sleep clk", clk_run, 1'b0);
		@(posedge mclk) bad_access <= 1'b1;
		@(posedge mclk) bad_access <= 1'b0;
		watch(8);
		chk("no wake bad", seen, 1'b0);
		chk("still asleep", sleep_reset_n, 1'b0);
		n0 = pconf_hits;
		@(posedge mclk) pin_combo_reset <= 1'b1;
		@(posedge mclk) pin_combo_reset <= 1'b0;
		watch(10);
		chk("combo wake", seen, 1'b1);
		settle();
		chk("clk back", clk_run, 1'b1);
		chk("pconf off", 32'(pconf_hits - n0), 32'h0);
		rdc("cause slept", 4'h4, 32'h48);
		rdc("ctrl kept", 4'h0, 32'hA0);
		rdc("slept rc", 4'h4, 32'h0);
	endtask
	task automatic t_wdrst();
		wr(4'h8, 32'h0A);
		wr(4'h8, 32'h03);
		wr(4'h0, 32'h10);
		wr(4'h0, 32'h0);
		rdc("wd en set", 4'h0, 32'h10);
		watch(40);
		chk("wd fired", seen, 1'b1);
		settle();
		rdc("cause wd", 4'h4, 32'h10);
	endtask
	task automatic t_cold();
		@(posedge mclk) ext_reset_n <= 1'b0;
		repeat (3) @(posedge mclk);
		chk("cold", cold_reset_n, 1'b0);
		chk("rc on", rc_osc_force, 1'b1);
		chk("xtal", xtal_osc_off, 1'b1);
		@(posedge mclk) ext_reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("pc restart", pc < 8, 1'b1);
		rdc("ctrl cold", 4'h0, 32'h0);
	endtask
	// ----------------------------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		{nrst, pin_combo_reset, bad_access, halt_req, wake_req} = '0;
		ext_reset_n = 1'b1;
		apb_req = '0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_wdog();
		t_bad();
		t_standby();
		t_sleep();
		t_wdrst();
		t_cold();
		complete_run();
	end
endmodule // reset_sleep_manager_tb
